// ==== src/sws_stack_wake_sequencer.sv ====
// Wake and resume sequencer for one device of a daisy-chained monitor stack.
// Assumes pins wake_req_n, uart_rx and chain inputs are asynchronous; the tone
// detector decodes periods of the tone on the low-side chain pin.
`timescale 1ns/100ps

// Notes on behaviour
// - At power-on bring up the always-on reference, then enter shutdown.
// - After the wake-ready delay, turn on aux regulator and accept wake requests.
// - Woken from shutdown, enable analog, digital supplies and references, then active.
// - After a full wake, send a wake tone of the wake tone count periods upward.
// - A received wake tone, or a resume tone while asleep, makes this device active and forward it.
// - Full wake from sleep reloads all registers from their programmed defaults.
// - Resume-without-reset goes from sleep to active keeping register contents.
// - Full wake from sleep completes within the full wake setup time.
// - Resume reaches active within resume setup time, then sends a resume tone.
// - A forwarded resume tone has no more than 40 tone periods.
// - Forwarded chain bits are re-timed to the nominal 250ns width.
module sws_stack_wake_sequencer #(
  parameter int WAKE_READY_CYC   = sws_pkg::WAKE_READY_CYC,
  parameter int FULL_SETUP_CYC   = sws_pkg::FULL_SETUP_CYC,
  parameter int RESUME_SETUP_CYC = sws_pkg::RESUME_SETUP_CYC,
  parameter int RESUME_LOW_CYC   = sws_pkg::RESUME_LOW_CYC
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              wake_req_n,
  input  wire logic              uart_rx,
  input  wire logic              low_side_link_pin,
  input  wire logic              chain_bit_in,
  input  wire logic              sleep_req,
  output sws_pkg::sws_power_t    power_r,
  output sws_pkg::sws_mode_t     mode_r,
  output logic                   otp_reload_r,
  output logic                   tone_out_r,
  output logic                   chain_bit_out_r
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [1:0] wake_sync_r;
  logic [1:0] rx_sync_r;
  logic [1:0] tone_sync_r;
  logic [1:0] bit_sync_r;
  logic       tone_prev_r;
  logic       bit_prev_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wake_sync_r <= 2'h3;
      rx_sync_r   <= 2'h3;
      tone_sync_r <= 2'h0;
      bit_sync_r  <= 2'h0;
      tone_prev_r <= 1'b0;
      bit_prev_r  <= 1'b0;
    end else begin
      wake_sync_r <= {wake_sync_r[0], wake_req_n};
      rx_sync_r   <= {rx_sync_r[0], uart_rx};
      tone_sync_r <= {tone_sync_r[0], low_side_link_pin};
      bit_sync_r  <= {bit_sync_r[0], chain_bit_in};
      tone_prev_r <= tone_sync_r[1];
      bit_prev_r  <= bit_sync_r[1];
    end
  end

  wire wake_low = ~wake_sync_r[1];
  wire rx_low   = ~rx_sync_r[1];
  wire tone_rise = tone_sync_r[1] & ~tone_prev_r;
  wire bit_rise  = bit_sync_r[1] & ~bit_prev_r;

  // ****************************************
  // Host request qualification
  // ****************************************
  logic [sws_pkg::CNT_W-1:0] wake_lo_cnt_r;
  logic [sws_pkg::CNT_W-1:0] rx_lo_cnt_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wake_lo_cnt_r <= '0;
      rx_lo_cnt_r   <= '0;
    end else begin
      wake_lo_cnt_r <= wake_low ? sat_inc(wake_lo_cnt_r) : '0;
      rx_lo_cnt_r   <= rx_low ? sat_inc(rx_lo_cnt_r) : '0;
    end
  end

  function automatic logic [sws_pkg::CNT_W-1:0] sat_inc(input logic [sws_pkg::CNT_W-1:0] v);
    sat_inc = (&v) ? v : v + 1'b1;
  endfunction

  // Wake taken on release of a long enough pulse, so a held pin fires once
  wire wake_pulse  = ~wake_low &
                     (wake_lo_cnt_r >= sws_pkg::CNT_W'(sws_pkg::WAKE_PULSE_CYC));
  wire resume_host = rx_lo_cnt_r == sws_pkg::CNT_W'(RESUME_LOW_CYC);

  // ****************************************
  // Tone detector
  // ****************************************
  // Periods are counted from rising edges spaced about one tone period apart.
  logic [sws_pkg::BIT_W-1:0]  gap_cnt_r;
  logic [sws_pkg::TONE_W-1:0] rx_periods_r;

  wire gap_ok   = (gap_cnt_r >= sws_pkg::BIT_W'(sws_pkg::TONE_PERIOD_CYC - 2)) &&
                  (gap_cnt_r <= sws_pkg::BIT_W'(sws_pkg::TONE_PERIOD_CYC + 2));
  wire gap_long = gap_cnt_r > sws_pkg::BIT_W'(2 * sws_pkg::TONE_PERIOD_CYC);
  wire wake_tone_seen   = rx_periods_r == sws_pkg::TONE_W'(sws_pkg::WAKE_TONE_COUNT) &&
                          gap_long;
  wire resume_tone_seen = rx_periods_r >= sws_pkg::TONE_W'(sws_pkg::RESUME_TONE_COUNT + 4) &&
                          gap_long;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gap_cnt_r    <= '0;
      rx_periods_r <= '0;
    end else begin
      gap_cnt_r <= tone_rise ? '0 : (&gap_cnt_r ? gap_cnt_r : gap_cnt_r + 1'b1);
      if (tone_rise)
        rx_periods_r <= gap_ok ? rx_periods_r + 1'b1 : sws_pkg::TONE_W'(1);
      else if (gap_long)
        rx_periods_r <= '0;
    end
  end

  // ****************************************
  // Mode sequencer
  // ****************************************
  sws_pkg::sws_mode_t         mode_nxt;
  sws_pkg::sws_tone_t         fwd_kind_r;
  sws_pkg::sws_tone_t         fwd_kind_nxt;
  logic                       full_wake_r;
  logic [sws_pkg::CNT_W-1:0]  tmr_r;
  wire                        tone_done;

  wire tmr_done_ready  = tmr_r >= sws_pkg::CNT_W'(WAKE_READY_CYC);
  wire tmr_done_por    = tmr_r >= sws_pkg::CNT_W'(sws_pkg::POR_SETTLE_CYC);
  // Wake and resume commit after a fixed settle inside the setup budget
  wire tmr_done_full   = tmr_r >= sws_pkg::CNT_W'(FULL_SETUP_CYC - 1);
  wire tmr_done_resume = tmr_r >= sws_pkg::CNT_W'(RESUME_SETUP_CYC - 1);
  wire wake_any        = wake_pulse | wake_tone_seen;
  wire resume_any      = resume_host | resume_tone_seen;

  always_comb begin
    mode_nxt     = mode_r;
    fwd_kind_nxt = fwd_kind_r;
    unique case (mode_r)
      sws_pkg::SWS_POR:
        if (tmr_done_por) mode_nxt = sws_pkg::SWS_SHUTDOWN;
      sws_pkg::SWS_SHUTDOWN:
        if (power_r.aux_regulator_out && wake_any) mode_nxt = sws_pkg::SWS_WAKING;
      sws_pkg::SWS_WAKING:
        if (tmr_done_full) begin
          mode_nxt     = sws_pkg::SWS_ACTIVE;
          fwd_kind_nxt = sws_pkg::SWS_TONE_WAKE;
        end
      sws_pkg::SWS_RESUMING:
        if (tmr_done_resume) begin
          mode_nxt     = sws_pkg::SWS_ACTIVE;
          fwd_kind_nxt = sws_pkg::SWS_TONE_RESUME;
        end
      sws_pkg::SWS_ACTIVE:
        if (sleep_req) mode_nxt = sws_pkg::SWS_SLEEP;
      sws_pkg::SWS_SLEEP:
        if (wake_any) mode_nxt = sws_pkg::SWS_WAKING;
        else if (resume_any) mode_nxt = sws_pkg::SWS_RESUMING;
      default:
        mode_nxt = sws_pkg::SWS_POR;
    endcase
    if (tone_done) fwd_kind_nxt = sws_pkg::SWS_TONE_NONE;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_r      <= sws_pkg::SWS_POR;
      fwd_kind_r  <= sws_pkg::SWS_TONE_NONE;
      full_wake_r <= 1'b0;
      tmr_r       <= '0;
    end else begin
      mode_r      <= mode_nxt;
      fwd_kind_r  <= fwd_kind_nxt;
      full_wake_r <= (mode_r == sws_pkg::SWS_SLEEP) && (mode_nxt == sws_pkg::SWS_WAKING);
      tmr_r       <= (mode_nxt != mode_r) ? '0 : sat_inc(tmr_r);
    end
  end

  // ****************************************
  // Power controls and register reload
  // ****************************************
  logic ready_seen_r;
  wire  supplies_on = (mode_nxt == sws_pkg::SWS_WAKING) || (mode_nxt == sws_pkg::SWS_RESUMING) ||
                      (mode_nxt == sws_pkg::SWS_ACTIVE);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      power_r      <= '0;
      ready_seen_r <= 1'b0;
      otp_reload_r <= 1'b0;
    end else begin
      power_r.always_on_analog_ref <= 1'b1;
      if (mode_r == sws_pkg::SWS_SHUTDOWN && tmr_done_ready)
        ready_seen_r <= 1'b1;
      power_r.aux_regulator_out        <= ready_seen_r;
      power_r.analog_supply_regulator  <= supplies_on;
      power_r.digital_supply_regulator <= supplies_on;
      power_r.references               <= supplies_on;
      // Resume path never pulses this, so register contents survive
      otp_reload_r <= full_wake_r;
    end
  end

  // ****************************************
  // Tone generator
  // ****************************************
  logic [sws_pkg::TONE_W-1:0] tone_per_r;
  logic [sws_pkg::BIT_W-1:0]  tone_ph_r;

  wire [sws_pkg::TONE_W-1:0] tone_len = (fwd_kind_r == sws_pkg::SWS_TONE_WAKE) ?
      sws_pkg::TONE_W'(sws_pkg::WAKE_TONE_COUNT) :
      sws_pkg::TONE_W'(sws_pkg::RESUME_TONE_COUNT + 4);
  wire tone_run  = (fwd_kind_r != sws_pkg::SWS_TONE_NONE) &&
                   (mode_r == sws_pkg::SWS_ACTIVE);
  wire ph_end    = tone_ph_r == sws_pkg::BIT_W'(sws_pkg::TONE_PERIOD_CYC - 1);
  assign tone_done = tone_run && ph_end && (tone_per_r == tone_len - 1'b1);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tone_per_r <= '0;
      tone_ph_r  <= '0;
      tone_out_r <= 1'b0;
    end else if (!tone_run) begin
      tone_per_r <= '0;
      tone_ph_r  <= '0;
      tone_out_r <= 1'b0;
    end else begin
      tone_ph_r  <= ph_end ? '0 : tone_ph_r + 1'b1;
      tone_per_r <= ph_end ? tone_per_r + 1'b1 : tone_per_r;
      tone_out_r <= tone_ph_r < sws_pkg::BIT_W'(sws_pkg::TONE_HALF_CYC);
    end
  end

  // ****************************************
  // Chain bit re-timer
  // ****************************************
  // Each incoming pulse while active restarts a fixed-width output pulse; width never shrinks per hop.
  logic [sws_pkg::BIT_W-1:0] bit_cnt_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bit_cnt_r       <= '0;
      chain_bit_out_r <= 1'b0;
    end else if (bit_rise && mode_r == sws_pkg::SWS_ACTIVE) begin
      bit_cnt_r       <= sws_pkg::BIT_W'(sws_pkg::BIT_WIDTH_CYC - 1);
      chain_bit_out_r <= 1'b1;
    end else if (bit_cnt_r != '0) begin
      bit_cnt_r       <= bit_cnt_r - 1'b1;
      chain_bit_out_r <= 1'b1;
    end else begin
      chain_bit_out_r <= 1'b0;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  int unsigned tone_periods_q;
  always_ff @(posedge clk) begin
    if (!rst_n || !tone_run) tone_periods_q <= 0;
    else if (ph_end) tone_periods_q <= tone_periods_q + 1;
  end

  // Length of the current high run of the re-timed bit
  int unsigned bit_hi_q;
  always_ff @(posedge clk) begin
    if (!rst_n || !chain_bit_out_r) bit_hi_q <= 0;
    else bit_hi_q <= bit_hi_q + 1;
  end

  por_to_shutdown_a: assert property (@(posedge clk) disable iff (!rst_n)
    mode_r == sws_pkg::SWS_SHUTDOWN |-> power_r.always_on_analog_ref)
    else $error("shutdown without always-on reference");
  aux_before_wake_a: assert property (@(posedge clk) disable iff (!rst_n)
    $past(mode_r) == sws_pkg::SWS_SHUTDOWN && mode_r == sws_pkg::SWS_WAKING
    |-> $past(power_r.aux_regulator_out))
    else $error("wake accepted before aux regulator on");
  supplies_active_a: assert property (@(posedge clk) disable iff (!rst_n)
    mode_r == sws_pkg::SWS_ACTIVE && $past(mode_r) == sws_pkg::SWS_ACTIVE
    |-> power_r.analog_supply_regulator && power_r.digital_supply_regulator)
    else $error("active without supplies");
  reload_full_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(mode_r == sws_pkg::SWS_WAKING) && $past(mode_r) == sws_pkg::SWS_SLEEP
    |-> ##1 otp_reload_r)
    else $error("full wake from sleep did not reload");
  resume_keeps_a: assert property (@(posedge clk) disable iff (!rst_n)
    mode_r == sws_pkg::SWS_RESUMING |-> ##1 !otp_reload_r)
    else $error("resume reloaded registers");
  tone_cap_a: assert property (@(posedge clk) disable iff (!rst_n)
    tone_periods_q <= sws_pkg::RESUME_TONE_MAX)
    else $error("too many tone periods");
  tone_after_active_a: assert property (@(posedge clk) disable iff (!rst_n)
    tone_out_r |-> $past(mode_r) == sws_pkg::SWS_ACTIVE)
    else $error("tone sent before active");
  bit_width_a: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(chain_bit_out_r) |-> bit_hi_q >= sws_pkg::BIT_WIDTH_CYC)
    else $error("re-timed bit too short");

  wake_seen_c: cover property (@(posedge clk) disable iff (!rst_n)
    mode_r == sws_pkg::SWS_WAKING ##1 mode_r == sws_pkg::SWS_WAKING);
  resume_seen_c: cover property (@(posedge clk) disable iff (!rst_n)
    mode_r == sws_pkg::SWS_RESUMING);
  tone_sent_c: cover property (@(posedge clk) disable iff (!rst_n) tone_done);

endmodule

// ==== src/sws_pkg.sv ====
// Package for the stack wake sequencer: timing constants, modes, tone kinds and power controls.
// Assumes a single 40 MHz clock; all times are converted to cycles here.
package sws_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int POR_SETTLE_NS = 1000;               // Always-on reference settle
  localparam int POR_SETTLE_CYC = (POR_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_READY_US = 2000;               // Power-on to wake-ready delay
  localparam int WAKE_READY_CYC = WAKE_READY_US * 1000 / CLK_PERIOD_NS;
  localparam int FULL_SETUP_US = 4000;               // Full wake setup time, longest
  localparam int FULL_SETUP_CYC = FULL_SETUP_US * 1000 / CLK_PERIOD_NS;
  localparam int RESUME_SETUP_US = 1000;             // Resume setup time, longest
  localparam int RESUME_SETUP_CYC = RESUME_SETUP_US * 1000 / CLK_PERIOD_NS;
  localparam int RESUME_LOW_US = 250;                // Resume start low time, least
  localparam int RESUME_LOW_CYC = (RESUME_LOW_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_PULSE_NS = 1000;               // Least wake pin pulse
  localparam int WAKE_PULSE_CYC = (WAKE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TONE_PERIOD_NS = 1000;              // Tone period
  localparam int TONE_PERIOD_CYC = TONE_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TONE_HALF_CYC = TONE_PERIOD_CYC / 2;
  localparam int WAKE_TONE_COUNT = 16;
  localparam int RESUME_TONE_COUNT = 16;
  localparam int RESUME_TONE_MAX = 40;               // Upper bound on resume tone periods
  localparam int BIT_WIDTH_NS = 250;                 // Nominal chain bit width
  localparam int BIT_WIDTH_CYC = BIT_WIDTH_NS / CLK_PERIOD_NS;
  localparam int MAX_STACK = 64;

  localparam int CNT_W = 24;
  localparam int TONE_W = 8;
  localparam int BIT_W = 8;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    SWS_POR      = 3'h0,
    SWS_SHUTDOWN = 3'h1,
    SWS_WAKING   = 3'h2,
    SWS_RESUMING = 3'h3,
    SWS_ACTIVE   = 3'h4,
    SWS_SLEEP    = 3'h5
  } sws_mode_t;

  typedef enum logic [1:0] {
    SWS_TONE_NONE   = 2'h0,
    SWS_TONE_WAKE   = 2'h1,
    SWS_TONE_RESUME = 2'h2
  } sws_tone_t;

  // Power controls driven by the sequencer
  typedef struct packed {
    logic always_on_analog_ref;
    logic aux_regulator_out;
    logic analog_supply_regulator;
    logic digital_supply_regulator;
    logic references;
  } sws_power_t;

endpackage

// ==== tb/sws_host_model.sv ====
// Host and lower-neighbour model: wake pin, receive line, tone input, chain bits.
// Assumes the bench calls its tasks; every change lands on a falling clock edge.
`timescale 1ns/100ps

module sws_host_model (
  input  wire logic clk,
  output logic      wake_req_n,
  output logic      uart_rx,
  output logic      low_side_link_pin,
  output logic      chain_bit_in
);
  localparam int TONE_HALF = 20;

  // Idle levels: pins released, link quiet between tones
  initial begin
    wake_req_n        = 1'b1;
    uart_rx           = 1'b1;
    low_side_link_pin = 1'b0;
    chain_bit_in      = 1'b0;
  end

  task automatic wake_pulse(input int n);
    @(negedge clk);
    wake_req_n = 1'b0;
    repeat (n) @(negedge clk);
    wake_req_n = 1'b1;
  endtask

  task automatic rx_low(input int n);
    @(negedge clk);
    uart_rx = 1'b0;
    repeat (n) @(negedge clk);
    uart_rx = 1'b1;
  endtask

  task automatic send_tone(input int periods);
    @(negedge clk);
    repeat (periods) begin
      low_side_link_pin = 1'b1;
      repeat (TONE_HALF) @(negedge clk);
      low_side_link_pin = 1'b0;
      repeat (TONE_HALF) @(negedge clk);
    end
  endtask

  task automatic chain_pulse(input int n);
    @(negedge clk);
    chain_bit_in = 1'b1;
    repeat (n) @(negedge clk);
    chain_bit_in = 1'b0;
  endtask
endmodule

// ==== tb/test_stack_wake_sequencer.sv ====
// Self-checking bench for the stack wake sequencer with shortened delays.
// Assumes the host model drives the pins; tones and reloads counted at falling edges.
`timescale 1ns/100ps

module test_stack_wake_sequencer;
  localparam int FSET  = 200;
  localparam int RSET  = 100;
  localparam int RLOW  = 50;
  localparam int TWAIT = 41 * 40;
  localparam int LIMIT = 20000;

  logic                clk       = 1'b0;
  logic                rst_n     = 1'b0;
  logic                sleep_req = 1'b0;
  logic                wake_req_n, uart_rx, link_pin, chain_in;
  sws_pkg::sws_power_t power_r;
  sws_pkg::sws_mode_t  mode_r;
  logic                otp_reload_r, tone_out_r, chain_bit_out_r;
  logic                tone_q    = 1'b0;
  int                  err_total = 0;
  int                  n_checks  = 0;
  int                  n_tone, n_otp, n_bit, i;
  int                  cyc       = 0;

  always #12.5 clk = ~clk;

  sws_host_model host (.clk(clk), .wake_req_n(wake_req_n), .uart_rx(uart_rx),
    .low_side_link_pin(link_pin), .chain_bit_in(chain_in));

  sws_stack_wake_sequencer #(.WAKE_READY_CYC(100), .FULL_SETUP_CYC(FSET),
    .RESUME_SETUP_CYC(RSET), .RESUME_LOW_CYC(RLOW)) dut (.clk(clk), .rst_n(rst_n),
    .wake_req_n(wake_req_n), .uart_rx(uart_rx), .low_side_link_pin(link_pin),
    .chain_bit_in(chain_in), .sleep_req(sleep_req), .power_r(power_r), .mode_r(mode_r),
    .otp_reload_r(otp_reload_r), .tone_out_r(tone_out_r), .chain_bit_out_r(chain_bit_out_r));

  // Monitor off the active edge so registered outputs have settled
  always @(negedge clk) begin
    cyc++;
    if (tone_out_r === 1'b1 && tone_q !== 1'b1) n_tone++;
    if (otp_reload_r === 1'b1) n_otp++;
    if (chain_bit_out_r === 1'b1) n_bit++;
    tone_q = tone_out_r;
    if (cyc == LIMIT) begin
      err_total++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic wait_mode(input sws_pkg::sws_mode_t m, input int lim);
    i = 0;
    while (mode_r !== m && i < lim) begin
      @(negedge clk);
      i++;
    end
    chk("mode", 32'(m), 32'(mode_r));
  endtask

  task automatic go_sleep();
    @(negedge clk);
    sleep_req = 1'b1;
    wait_mode(sws_pkg::SWS_SLEEP, 10);
    sleep_req = 1'b0;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_power_on();
    chk("reset mode", 32'(sws_pkg::SWS_POR), 32'(mode_r));
    chk("reset power", 32'h0, 32'(power_r));
    rst_n = 1'b1;
    wait_mode(sws_pkg::SWS_SHUTDOWN, 60);
    chk("ref on", 32'h1, 32'(power_r.always_on_analog_ref));
    // Early wake must be ignored until aux is up
    host.wake_pulse(45);
    repeat (8) @(negedge clk);
    chk("early wake", 32'(sws_pkg::SWS_SHUTDOWN), 32'(mode_r));
    chk("aux early", 32'h0, 32'(power_r.aux_regulator_out));
    i = 0;
    while (power_r.aux_regulator_out !== 1'b1 && i < 120) begin
      @(negedge clk);
      i++;
    end
    chk("aux on", 32'h1, 32'(power_r.aux_regulator_out));
    $display("test power_on done");
  endtask

  task automatic t_full_wake(input bit from_sleep);
    n_tone = 0;
    n_otp = 0;
    host.wake_pulse(45);
    wait_mode(sws_pkg::SWS_WAKING, 10);
    wait_mode(sws_pkg::SWS_ACTIVE, FSET + 10);
    chk("tone early", 32'h0, 32'(n_tone));
    chk("supplies", 32'h7, {29'h0, power_r.analog_supply_regulator,
      power_r.digital_supply_regulator, power_r.references});
    repeat (TWAIT) @(negedge clk);
    chk("wake tones", 32'(sws_pkg::WAKE_TONE_COUNT), 32'(n_tone));
    if (from_sleep) chk("reload", 32'h1, 32'(n_otp));
    $display("test full_wake done");
  endtask

  task automatic t_retime();
    n_bit = 0;
    host.chain_pulse(3);
    repeat (20) @(negedge clk);
    chk("bit width", 32'(sws_pkg::BIT_WIDTH_CYC), 32'(n_bit));
    $display("test retime done");
  endtask

  task automatic t_resume();
    go_sleep();
    n_bit = 0;
    host.chain_pulse(3);
    repeat (20) @(negedge clk);
    chk("bit in sleep", 32'h0, 32'(n_bit));
    n_tone = 0;
    n_otp = 0;
    host.rx_low(RLOW);
    wait_mode(sws_pkg::SWS_RESUMING, 10);
    wait_mode(sws_pkg::SWS_ACTIVE, RSET + 10);
    chk("tone early", 32'h0, 32'(n_tone));
    repeat (TWAIT) @(negedge clk);
    chk("no reload", 32'h0, 32'(n_otp));
    chk("resume tones", 32'h14, 32'(n_tone));
    chk("tone cap", 32'h1, 32'(n_tone <= sws_pkg::RESUME_TONE_MAX));
    $display("test resume done");
  endtask

  task automatic t_tone_in(input int periods);
    go_sleep();
    n_tone = 0;
    host.send_tone(periods);
    wait_mode(sws_pkg::SWS_ACTIVE, FSET + 150);
    chk("tone early", 32'h0, 32'(n_tone));
    repeat (TWAIT) @(negedge clk);
    chk("forwarded", 32'(periods), 32'(n_tone));
    $display("test tone_in done");
  endtask

  initial begin
    repeat (8) @(negedge clk);
    t_power_on();
    t_full_wake(1'b0);
    t_retime();
    t_resume();
    go_sleep();
    t_full_wake(1'b1);
    t_tone_in(sws_pkg::WAKE_TONE_COUNT);
    t_tone_in(20);
    print_verdict();
  end
endmodule
